// ### src/phm_mdio_if.sv
// Purpose: Management link between controller and PHY
// Assumes: Idle line is pulled high
// Notes: Line level resolved here from the two output enables
`timescale 1ns/1ns
`default_nettype none
interface phm_mdio_if;
  logic mdc;
  logic host_mdo;
  logic host_oe;
  logic dev_mdo;
  logic dev_oe;
  logic mdio;
  assign mdio = dev_oe ? dev_mdo : (host_oe ? host_mdo : 1'b1);
  modport host (output mdc, output host_mdo, output host_oe, input mdio);
  modport dev (input mdc, output dev_mdo, output dev_oe, input mdio);
endinterface : phm_mdio_if
`default_nettype wire

// ### src/phm_phy_end.sv
// Purpose: PHY side management, configuration, power and sleep control
// Assumes: Pins and the management clock are asynchronous to ref_clk
// Notes: srst is the hardware reset; sw reset comes from control bit 15
`timescale 1ns/1ns
`default_nettype none
// Contract
// - 32 registers of 16 bits addressed
// - Disable pin high ignores all frames
// - Disable pin low accepts reads and writes
// - Answer only frames matching address pins
// - Interrupt line low only when enabled
// - Four events; enable reg 18, status 19
// - Controller keeps management clock at most 8MHz
// - Reevaluate link mode on reset, link failure
// - Managed mode: pins give defaults, then writes
// - Hardware mode blocks writes, pins set registers
// - Forced mode runs at once, else autoneg
// - Power-down pin stops port, tristates, refuses access
// - Control bit 11 stops port, registers stay
// - Sleep pin enables; bit 16.6 overrides managed
// - Sleep after 1-3 s without energy
// - Management still answers while asleep
// - Energy wakes; no link in window sleeps
// - No sleep in fiber mode
// - Hardware reset captures pin configuration
// - Software reset restores captured pins, no resample
// - No register access for 1 ms after reset
// - Registers readable in sw reset; bit self-clears
module phm_phy_end #(
  parameter int MS_CYCLES = phm_pkg::MS_CYCLES_DEF
) (
  input wire logic ref_clk,                 // System clock
  input wire logic srst,                    // Hardware reset, active high
  phm_mdio_if.dev mif,                      // Management link
  input wire logic mgmt_port_disable_pin,   // High selects hardware control
  input wire logic hw_power_down_pin,       // High powers the device down
  input wire logic [4:0] phy_addr,          // Chip address straps
  input wire logic [2:0] cfg_pins,          // Autoneg, speed, duplex straps
  input wire logic fiber_sd_pin,            // Signal detect strap for fiber
  input wire logic sleep_pin,               // Sleep enable pin
  input wire logic energy_det,              // Twisted-pair energy seen
  input wire logic link_up,                 // Link status from the port
  input wire logic an_done,                 // Autoneg complete
  input wire logic speed_100,               // Resolved speed is 100
  input wire logic duplex_full,             // Resolved duplex is full
  output logic status_change_irq_n,         // Interrupt, active low
  output logic an_enable,                   // Autoneg with parallel detect
  output logic an_start,                    // Pulse: (re)start link bring-up
  output logic speed_100_sel,               // Forced speed 100
  output logic full_duplex_sel,             // Forced full duplex
  output logic fiber_sel,                   // Fiber mode
  output logic port_enable,                 // Network port running
  output logic outputs_hiz,                 // All outputs tristated
  output logic pulls_enable,                // Weak pad pulls enabled
  output logic sleeping                     // In sleep state
);
  import phm_pkg::*;

  typedef enum logic [2:0] {FR_PRE, FR_ST, FR_HDR, FR_RTA, FR_RDAT, FR_WTA, FR_WDAT} phm_fr_t;
  typedef enum logic [1:0] {SL_AWAKE, SL_ASLEEP, SL_CHECK} phm_sl_t;

  logic [15:0] pin_q;
  logic mdc_q, mdi_q, dis_q, pd_q, sleep_q, energy_q, link_q, an_q, spd_q, dup_q;
  logic sd_q;
  logic [2:0] cfg_q;
  phm_sync3 #(.W(16)) u_sync (
    .clk(ref_clk),
    .srst(srst),
    .d({mif.mdc, mif.mdio, mgmt_port_disable_pin, hw_power_down_pin, sleep_pin, energy_det,
        link_up, an_done, speed_100, duplex_full, fiber_sd_pin, cfg_pins, 2'b00}),
    .q(pin_q)
  );
  assign {mdc_q, mdi_q, dis_q, pd_q, sleep_q, energy_q, link_q, an_q, spd_q, dup_q,
          sd_q, cfg_q} = pin_q[15:2];

  function automatic logic [15:0] ctrl_from(input logic [2:0] c);
    logic [15:0] v;
    v = REG_RST;
    v[CTRL_AN] = c[2];
    v[CTRL_SPEED] = c[2] | c[1];
    v[CTRL_DUPLEX] = c[0];
    return v;
  endfunction : ctrl_from

  function automatic logic [15:0] adv_from(input logic [2:0] c);
    logic [15:0] v;
    v = REG_RST;
    v[8:5] = c[2] ? {c[0], 1'b1, c[1] & c[0], c[1]} : 4'hf;
    return v;
  endfunction : adv_from

  // Millisecond tick, boot settling and 1 ms access hold-off
  logic [31:0] ms_pre;
  logic ms_tick;
  logic [2:0] settle;
  logic [7:0] boot_ms;
  logic regs_ready;
  logic load_cfg;
  assign ms_tick = (ms_pre == 32'(MS_CYCLES - 1));
  assign load_cfg = (settle == 3'(CFG_SETTLE - 1));
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ms_pre <= '0;
    end else begin
      ms_pre <= ms_tick ? '0 : ms_pre + 32'd1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      settle <= '0;
      boot_ms <= '0;
      regs_ready <= 1'b0;
    end else begin
      if (settle != 3'(CFG_SETTLE)) settle <= settle + 3'd1;
      if (ms_tick && !regs_ready) boot_ms <= boot_ms + 8'd1;
      if (ms_tick && boot_ms == 8'(RESET_WAIT_MS - 1)) regs_ready <= 1'b1;
    end
  end

  // Straps caught once after release so sw reset can replay them
  logic [4:0] hw_cfg;
  logic [4:0] cap_val;
  assign cap_val = load_cfg ? {sleep_q, sd_q, cfg_q} : hw_cfg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hw_cfg <= '0;
    end else if (load_cfg) begin
      hw_cfg <= {sleep_q, sd_q, cfg_q};
    end
  end

  logic wr_stb;
  logic rd_stb;
  logic [4:0] hdr_reg;
  logic [15:0] wr_data;
  logic sw_rst_req;
  logic [4:0] swrst_cnt;
  logic swrst_end;
  logic [15:0] ctrl, adv, conf, irq_en, irq_st;
  assign sw_rst_req = wr_stb && hdr_reg == REG_CTRL && wr_data[CTRL_RESET];
  assign swrst_end = (swrst_cnt == 5'd1);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      swrst_cnt <= '0;
    end else if (sw_rst_req) begin
      swrst_cnt <= 5'(SWRST_CYCLES);
    end else if (swrst_cnt != 5'd0) begin
      swrst_cnt <= swrst_cnt - 5'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl <= REG_RST;
      adv <= REG_RST;
      conf <= REG_RST;
      irq_en <= IRQ_EN_RST;
    end else if (load_cfg || sw_rst_req) begin
      ctrl <= ctrl_from(cap_val[2:0]);
      ctrl[CTRL_RESET] <= sw_rst_req;
      adv <= adv_from(cap_val[2:0]);
      conf <= REG_RST;
      conf[CONF_SLEEP] <= cap_val[4];
      conf[CONF_TSEL +: 2] <= TSEL_DEF;
      conf[CONF_FIBER] <= cap_val[3];
      irq_en <= IRQ_EN_RST;
    end else begin
      if (swrst_end) ctrl[CTRL_RESET] <= 1'b0;
      if (wr_stb) begin
        case (hdr_reg)
          REG_CTRL: ctrl <= wr_data;
          REG_ADV: adv <= wr_data;
          REG_CONF: conf <= wr_data;
          REG_IRQ_EN: irq_en <= wr_data;
          default: ;
        endcase
      end
    end
  end

  // Status events; a new event beats the clear-on-read
  logic link_d, an_d, spd_d, dup_d;
  logic [3:0] ev;
  assign ev = {an_q & ~an_d, spd_q ^ spd_d, dup_q ^ dup_d, link_q ^ link_d};
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      {link_d, an_d, spd_d, dup_d} <= '0;
      irq_st <= REG_RST;
    end else begin
      {link_d, an_d, spd_d, dup_d} <= {link_q, an_q, spd_q, dup_q};
      if (rd_stb && hdr_reg == REG_IRQ_ST) irq_st <= REG_RST;
      irq_st[EV_LO +: 4] <= ev | (rd_stb && hdr_reg == REG_IRQ_ST ? 4'h0 : irq_st[EV_LO +: 4]);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_change_irq_n <= 1'b1;
    end else begin
      status_change_irq_n <= ~(irq_en[IRQ_ENABLE] & |(irq_st[EV_LO +: 4] & irq_en[EV_LO +: 4]));
    end
  end

  // Strap load seen one cycle late, so bring-up starts on loaded registers
  logic load_d;
  always_ff @(posedge ref_clk) begin
    load_d <= load_cfg & ~srst;
  end

  // Link mode outputs follow the configuration registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      an_enable <= 1'b0;
      an_start <= 1'b0;
      speed_100_sel <= 1'b0;
      full_duplex_sel <= 1'b0;
      fiber_sel <= 1'b0;
      port_enable <= 1'b0;
      outputs_hiz <= 1'b0;
      pulls_enable <= 1'b1;
    end else begin
      an_enable <= ctrl[CTRL_AN] & ~conf[CONF_FIBER];
      speed_100_sel <= ctrl[CTRL_SPEED] | conf[CONF_FIBER];
      full_duplex_sel <= ctrl[CTRL_DUPLEX];
      fiber_sel <= conf[CONF_FIBER];
      an_start <= (settle == 3'(CFG_SETTLE) && load_d) || swrst_end || (link_d & ~link_q);
      port_enable <= ~pd_q & ~ctrl[CTRL_PDOWN] & ~sleeping;
      outputs_hiz <= pd_q;
      pulls_enable <= ~pd_q;
    end
  end

  // Sleep: energy watchdog with programmable timeout in ms
  phm_sl_t sl_state;
  logic [11:0] sl_ms;
  logic [11:0] to_ms;
  logic sleep_allowed;
  always_comb begin
    case (conf[CONF_TSEL +: 2])
      2'h0: to_ms = SLEEP_MS_0;
      2'h1: to_ms = SLEEP_MS_1;
      default: to_ms = SLEEP_MS_2;
    endcase
  end
  assign sleep_allowed = (dis_q ? sleep_q : conf[CONF_SLEEP]) & ~conf[CONF_FIBER];
  always_ff @(posedge ref_clk) begin
    if (srst || !sleep_allowed) begin
      sl_state <= SL_AWAKE;
      sl_ms <= '0;
    end else begin
      case (sl_state)
        SL_AWAKE: begin
          if (energy_q) begin
            sl_ms <= '0;
          end else if (ms_tick) begin
            sl_ms <= (sl_ms == to_ms - 12'd1) ? 12'd0 : sl_ms + 12'd1;
            if (sl_ms == to_ms - 12'd1) sl_state <= SL_ASLEEP;
          end
        end
        SL_ASLEEP: begin
          sl_ms <= '0;
          if (energy_q) sl_state <= SL_CHECK;
        end
        SL_CHECK: begin
          if (link_q) begin
            sl_state <= SL_AWAKE;
            sl_ms <= '0;
          end else if (ms_tick) begin
            sl_ms <= (sl_ms == to_ms - 12'd1) ? 12'd0 : sl_ms + 12'd1;
            if (sl_ms == to_ms - 12'd1) sl_state <= SL_ASLEEP;
          end
        end
        default: sl_state <= SL_AWAKE;
      endcase
    end
  end
  assign sleeping = (sl_state == SL_ASLEEP);

  // Register read mux; unimplemented numbers read zero
  logic [15:0] rd_val;
  always_comb begin
    rd_val = REG_RST;
    case (hdr_reg)
      REG_CTRL: rd_val = ctrl;
      REG_STAT: begin
        rd_val[STAT_AN_DONE] = an_q;
        rd_val[STAT_LINK] = link_q;
      end
      REG_ADV: rd_val = adv;
      REG_CONF: rd_val = conf;
      REG_IRQ_EN: rd_val = irq_en;
      REG_IRQ_ST: rd_val = irq_st;
      default: rd_val = REG_RST;
    endcase
  end

  // Frame engine, stepped on each sampled MDC rise; asleep or not
  phm_fr_t fr;
  logic mdc_d;
  logic mdc_rise;
  logic [5:0] bcnt;
  logic [11:0] hdr;
  logic [15:0] sh;
  logic accept;
  assign mdc_rise = mdc_q & ~mdc_d;
  assign accept = regs_ready & ~dis_q & ~pd_q;
  assign wr_stb = mdc_rise && fr == FR_WDAT && bcnt == 6'd15;
  assign rd_stb = mdc_rise && fr == FR_RTA;
  assign wr_data = {sh[14:0], mdi_q};
  assign hdr_reg = hdr[4:0];
  always_ff @(posedge ref_clk) begin
    if (srst || pd_q) begin
      fr <= FR_PRE;
      mdc_d <= 1'b0;
      bcnt <= '0;
      hdr <= '0;
      sh <= '0;
      mif.dev_oe <= 1'b0;
      mif.dev_mdo <= 1'b1;
    end else begin
      mdc_d <= mdc_q;
      if (mdc_rise) begin
        case (fr)
          FR_PRE: begin
            if (mdi_q) begin
              if (bcnt != 6'(PREAMBLE_BITS)) bcnt <= bcnt + 6'd1;
            end else begin
              bcnt <= '0;
              if (bcnt == 6'(PREAMBLE_BITS)) fr <= FR_ST;
            end
          end
          FR_ST: begin
            bcnt <= '0;
            fr <= (mdi_q == FR_START[0]) ? FR_HDR : FR_PRE;
          end
          FR_HDR: begin
            hdr <= {hdr[10:0], mdi_q};
            bcnt <= bcnt + 6'd1;
            if (bcnt == 6'd11) begin
              bcnt <= '0;
              if (!accept || hdr[8:4] != phy_addr) begin
                fr <= FR_PRE;
              end else if (hdr[10:9] == OP_READ) begin
                fr <= FR_RTA;
              end else if (hdr[10:9] == OP_WRITE) begin
                fr <= FR_WTA;
              end else begin
                fr <= FR_PRE;
              end
            end
          end
          FR_RTA: begin
            sh <= rd_val;
            mif.dev_oe <= 1'b1;
            mif.dev_mdo <= 1'b0;
            fr <= FR_RDAT;
          end
          FR_RDAT: begin
            mif.dev_mdo <= sh[15];
            sh <= {sh[14:0], 1'b0};
            bcnt <= bcnt + 6'd1;
            if (bcnt == 6'd16) begin
              mif.dev_oe <= 1'b0;
              mif.dev_mdo <= 1'b1;
              bcnt <= '0;
              fr <= FR_PRE;
            end
          end
          FR_WTA: begin
            bcnt <= bcnt + 6'd1;
            if (bcnt == 6'd1) begin
              bcnt <= '0;
              fr <= FR_WDAT;
            end
          end
          FR_WDAT: begin
            sh <= wr_data;
            bcnt <= bcnt + 6'd1;
            if (bcnt == 6'd15) begin
              bcnt <= '0;
              fr <= FR_PRE;
            end
          end
          default: fr <= FR_PRE;
        endcase
      end
    end
  end
endmodule : phm_phy_end
`default_nettype wire

// ### src/phm_pkg.sv
// Purpose: Shared constants for the PHY management port and its controller
// Assumes: 125 MHz ref_clk on both ends
// Notes: Times are kept in their own unit; cycle counts derive from them
package phm_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int MS_CYCLES_DEF = CLK_HZ / 1000;
  localparam int RESET_WAIT_MS = 1;
  localparam int MDC_MAX_HZ = 8_000_000;
  localparam int MDC_HALF_MIN = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
  localparam int CFG_SETTLE = 4;
  localparam int SWRST_CYCLES = 16;
  localparam int PREAMBLE_BITS = 32;
  localparam int FRAME_BITS = 64;
  localparam int TA_IDX = 46;
  localparam int DATA_IDX = 48;
  // Frame fields
  localparam logic [1:0] FR_START = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] FR_TA = 2'b10;
  // Register numbers
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_CONF = 5'h10;
  localparam logic [4:0] REG_IRQ_EN = 5'h12;
  localparam logic [4:0] REG_IRQ_ST = 5'h13;
  // Bit positions
  localparam int CTRL_RESET = 15;
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_AN = 12;
  localparam int CTRL_PDOWN = 11;
  localparam int CTRL_DUPLEX = 8;
  localparam int STAT_AN_DONE = 5;
  localparam int STAT_LINK = 2;
  localparam int CONF_SLEEP = 6;
  localparam int CONF_TSEL = 3;
  localparam int CONF_FIBER = 0;
  localparam int IRQ_ENABLE = 1;
  localparam int EV_LO = 4;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] IRQ_EN_RST = 16'h0000;
  // Sleep timeout choices in ms
  localparam logic [1:0] TSEL_DEF = 2'h2;
  localparam logic [11:0] SLEEP_MS_0 = 12'd1040;
  localparam logic [11:0] SLEEP_MS_1 = 12'd2000;
  localparam logic [11:0] SLEEP_MS_2 = 12'd3040;
  // Controller APB map
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_RDATA = 8'h08;
  localparam int CMD_WRITE = 26;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_READY = 2;
endpackage : phm_pkg

// ### src/phm_sta_end.sv
// Purpose: Station management controller with APB command registers
// Assumes: APB on ref_clk; one frame at a time
// Notes: MDC is divided from ref_clk and driven out on the link
`timescale 1ns/1ns
`default_nettype none
module phm_sta_end #(
  parameter int MDC_HALF = phm_pkg::MDC_HALF_MIN,
  parameter int MS_CYCLES = phm_pkg::MS_CYCLES_DEF
) (
  input wire logic ref_clk,        // System clock
  input wire logic srst,           // Sync reset, active high
  input wire logic psel,           // APB select
  input wire logic penable,        // APB access phase
  input wire logic pwrite,         // APB write
  input wire logic [7:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,      // APB read data
  output logic pready,             // APB ready
  output logic pslverr,            // APB error on unmapped address
  phm_mdio_if.host mif             // Management link
);
  import phm_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} phm_st_t;

  logic [15:0] mdi_s;
  logic mdi_q;
  phm_sync3 #(.W(1)) u_sync (
    .clk(ref_clk),
    .srst(srst),
    .d(mif.mdio),
    .q(mdi_q)
  );

  phm_st_t st;
  logic [7:0] half;
  logic [6:0] idx;
  logic [63:0] seq;
  logic is_read;
  logic done;
  logic [31:0] wait_cnt;
  logic link_ready;
  logic apb_acc;
  logic cmd_go;
  logic mapped;
  assign apb_acc = psel & penable;
  assign pready = 1'b1;
  assign mapped = paddr == APB_CMD || paddr == APB_STATUS || paddr == APB_RDATA;
  assign pslverr = apb_acc & ~mapped;
  assign cmd_go = apb_acc && pwrite && paddr == APB_CMD && st == ST_IDLE && link_ready;

  // Hold off frames for the device's post-reset window
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wait_cnt <= '0;
      link_ready <= 1'b0;
    end else if (!link_ready) begin
      wait_cnt <= wait_cnt + 32'd1;
      if (wait_cnt == 32'(RESET_WAIT_MS * MS_CYCLES - 1)) link_ready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= '0;
    end else begin
      case (paddr)
        APB_STATUS: prdata <= {29'h0, link_ready, done, st != ST_IDLE};
        APB_RDATA: prdata <= {16'h0, mdi_s};
        default: prdata <= '0;
      endcase
    end
  end

  // MDC half period never shorter than the 8 MHz limit allows
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= ST_IDLE;
      half <= '0;
      idx <= '0;
      seq <= '0;
      is_read <= 1'b0;
      done <= 1'b0;
      mdi_s <= '0;
      mif.mdc <= 1'b0;
      mif.host_oe <= 1'b0;
      mif.host_mdo <= 1'b1;
    end else begin
      case (st)
        ST_IDLE: begin
          if (cmd_go) begin
            seq <= {{PREAMBLE_BITS{1'b1}}, FR_START, pwdata[CMD_WRITE] ? OP_WRITE : OP_READ,
                    pwdata[25:16], FR_TA, pwdata[15:0]};
            is_read <= ~pwdata[CMD_WRITE];
            done <= 1'b0;
            idx <= '0;
            half <= '0;
            mif.host_oe <= 1'b1;
            mif.host_mdo <= 1'b1;
            st <= ST_LOW;
          end
        end
        ST_LOW: begin
          half <= half + 8'd1;
          if (half == 8'(MDC_HALF - 1)) begin
            half <= '0;
            mif.mdc <= 1'b1;
            if (is_read && idx >= 7'(DATA_IDX)) mdi_s <= {mdi_s[14:0], mdi_q};
            st <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          half <= half + 8'd1;
          if (half == 8'(MDC_HALF - 1)) begin
            half <= '0;
            mif.mdc <= 1'b0;
            if (idx == 7'(FRAME_BITS - 1)) begin
              mif.host_oe <= 1'b0;
              mif.host_mdo <= 1'b1;
              done <= 1'b1;
              st <= ST_IDLE;
            end else begin
              idx <= idx + 7'd1;
              mif.host_mdo <= seq[6'(FRAME_BITS - 2) - idx[5:0]];
              mif.host_oe <= ~(is_read && idx + 7'd1 >= 7'(TA_IDX));
              st <= ST_LOW;
            end
          end
        end
        default: st <= ST_IDLE;
      endcase
      if (st == ST_IDLE && cmd_go) mif.host_mdo <= 1'b1;
    end
  end
endmodule : phm_sta_end
`default_nettype wire

// ### src/phm_sync3.sv
// Purpose: Three-flop input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk
// Notes: Output moves only when the second and third stages agree
`timescale 1ns/1ns
`default_nettype none
module phm_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,        // Sampling clock
  input wire logic srst,       // Sync reset
  input wire logic [W-1:0] d,  // Async inputs
  output logic [W-1:0] q       // Filtered outputs
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  always_ff @(posedge clk) begin
    s1 <= d;
    s2 <= s1;
    s3 <= s2;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= (s2 & s3) | (q & (s2 ^ s3));
    end
  end
endmodule : phm_sync3
`default_nettype wire

// ### testbench/phm_link_asserts.sv
// Purpose: Link checks beside the joined interface
// Assumes: One clock domain, ref_clk
// Notes: Sees plain interface signals only
`timescale 1ns/1ns
`default_nettype none
module phm_link_asserts #(
  parameter int MS_CYCLES = 50,
  parameter int MDC_HALF = 8
) (
  input wire logic ref_clk, // Clock
  input wire logic srst, // Reset
  input wire logic mdc, // Link clock
  input wire logic host_mdo, // Host data
  input wire logic host_oe, // Host drive
  input wire logic dev_mdo, // PHY data
  input wire logic dev_oe, // PHY drive
  input wire logic mdio // Line
);
  // Second turnaround bit plus 16 data bits
  localparam int RD = 34 * MDC_HALF;
  int boot;
  int run;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  always_ff @(posedge ref_clk) boot <= srst ? 0 : (boot < MS_CYCLES ? boot + 1 : boot);
  always_ff @(posedge ref_clk) run <= (srst || !dev_oe) ? 0 : run + 1;
  a_one_driver: assert property (!(host_oe && dev_oe))
    else $error("both drive");
  a_mdc_slow: assert property ($changed(mdc) |=> $stable(mdc) [*7])
    else $error("mdc fast");
  a_start_quiet: assert property ($fell(srst) |-> !host_oe && !dev_oe && !mdc)
    else $error("drive in reset");
  a_boot_quiet: assert property (boot < MS_CYCLES |-> !dev_oe)
    else $error("early answer");
  a_ta_zero: assert property ($rose(dev_oe) |-> !dev_mdo && !mdio)
    else $error("bad turnaround");
  a_preamble_ones: assert property ($rose(host_oe) |-> host_mdo [*8])
    else $error("bad preamble");
  a_mdo_mdc_low: assert property (host_oe && $changed(host_mdo) |-> !mdc)
    else $error("data moved on high");
  a_read_span: assert property ($fell(dev_oe) |-> run >= RD - 4 && run <= RD + 4)
    else $error("bad read length");
  c_read: cover property ($fell(dev_oe));
  c_frame: cover property ($rose(host_oe));
  c_boot: cover property (boot == MS_CYCLES);
endmodule : phm_link_asserts
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: Joined controller and PHY, driven over APB
// Assumes: 1 ms shortened to MS cycles on both ends
// Notes: Straps and status inputs come from the bench
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import phm_pkg::*;
  localparam int MS = 50;
  logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic dis = 0, pd = 0, en = 0, lk = 0, an = 0, sp = 0, dx = 0, irq_n, pen, hiz, slp;
  logic ane, pul;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] q;
  logic [4:0] pa = 5'h03;
  logic [2:0] cfg = 3'h7;
  int fail_count = 0, checked = 0;
  always #4 ref_clk = ~ref_clk;
  phm_mdio_if u_phm_mdio_if ();
  phm_sta_end #(.MS_CYCLES(MS)) u_phm_sta_end (.ref_clk, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mif(u_phm_mdio_if));
  phm_phy_end #(.MS_CYCLES(MS)) u_phm_phy_end (.ref_clk, .srst, .mif(u_phm_mdio_if),
    .mgmt_port_disable_pin(dis), .hw_power_down_pin(pd), .phy_addr(pa), .cfg_pins(cfg),
    .fiber_sd_pin(1'h0), .sleep_pin(1'h0), .energy_det(en), .link_up(lk), .an_done(an),
    .speed_100(sp), .duplex_full(dx), .status_change_irq_n(irq_n), .an_enable(ane), .an_start(),
    .speed_100_sel(), .full_duplex_sel(), .fiber_sel(), .port_enable(pen), .outputs_hiz(hiz),
    .pulls_enable(pul), .sleeping(slp));
  phm_link_asserts #(.MS_CYCLES(MS), .MDC_HALF(MDC_HALF_MIN)) u_phm_link_asserts (.ref_clk,
    .srst, .mdc(u_phm_mdio_if.mdc), .host_mdo(u_phm_mdio_if.host_mdo),
    .host_oe(u_phm_mdio_if.host_oe), .dev_mdo(u_phm_mdio_if.dev_mdo),
    .dev_oe(u_phm_mdio_if.dev_oe), .mdio(u_phm_mdio_if.mdio));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic tmo(input logic ok);
    if (ok !== 1'h1) begin
      fail_count++;
      $display("wrong value at %0t: no answer", $time);
      close_out();
    end
  endtask : tmo
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    tmo(pready);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic mg(input logic w, input logic [4:0] p, input logic [4:0] g,
      input logic [15:0] d);
    int n = 0;
    apb(1'h1, APB_CMD, {5'h00, w, p, g, d});
    do begin
      apb(1'h0, APB_STATUS, 32'h0);
      n++;
    end while (r[ST_DONE] !== 1'h1 && n < 600);
    tmo(r[ST_DONE]);
    apb(1'h0, APB_RDATA, 32'h0);
    q = r[15:0];
  endtask : mg
  task automatic rd(input logic [4:0] g);
    mg(1'h0, pa, g, 16'h0);
  endtask : rd
  task automatic wr(input logic [4:0] g, input logic [15:0] d);
    mg(1'h1, pa, g, d);
  endtask : wr
  task automatic restart;
    srst <= 1'h1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'h0;
    apb(1'h0, APB_STATUS, 32'h0);
    chk(r[ST_READY], 32'h0);
    for (int i = 0; i < 40 && r[ST_READY] !== 1'h1; i++) apb(1'h0, APB_STATUS, 32'h0);
    tmo(r[ST_READY]);
  endtask : restart
  initial begin
    restart();
    rd(REG_CTRL);
    chk(q, 32'h3100);
    chk(ane, 32'h1);
    mg(1'h0, 5'h04, REG_CTRL, 16'h0);
    chk(q, 32'hffff);
    apb(1'h0, 8'h0c, 32'h0);
    chk(e, 32'h1);
    $display("boot test done");
    wr(REG_IRQ_EN, 16'h00f2);
    rd(REG_IRQ_EN);
    chk(q, 32'hf2);
    for (int i = 0; i < 4; i++) begin
      {an, sp, dx, lk} <= {an, sp, dx, lk} ^ (4'h8 >> i);
      repeat (12) @(posedge ref_clk);
      chk(irq_n, 32'h0);
      rd(REG_IRQ_ST);
      chk(q, 32'h80 >> i);
      chk(irq_n, 32'h1);
    end
    $display("irq test done");
    cfg <= 3'h0;
    wr(REG_CTRL, 16'h8000);
    rd(REG_CTRL);
    chk(q, 32'h3100);
    wr(REG_CTRL, 16'h3900);
    chk(pen, 32'h0);
    rd(REG_CTRL);
    chk(q, 32'h3900);
    dis <= 1'h1;
    wr(REG_CTRL, 16'h3100);
    rd(REG_CTRL);
    chk(q, 32'hffff);
    dis <= 1'h0;
    rd(REG_CTRL);
    chk(q, 32'h3900);
    $display("reset test done");
    pd <= 1'h1;
    rd(REG_CTRL);
    chk(q, 32'hffff);
    chk(hiz, 32'h1);
    chk(pul, 32'h0);
    pd <= 1'h0;
    restart();
    rd(REG_CTRL);
    chk(q, 32'h0);
    chk(ane, 32'h0);
    $display("power test done");
    wr(REG_CONF, 16'h0040);
    for (int i = 0; i < 1100 * MS && slp !== 1'h1; i++) @(posedge ref_clk);
    tmo(slp);
    rd(REG_CONF);
    chk(q, 32'h40);
    en <= 1'h1;
    repeat (12) @(posedge ref_clk);
    chk(slp, 32'h0);
    $display("sleep test done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
